// File: rtl/cxo_pkg.sv
// Package for the transfer and negative/zero check execution block.
// Assumes one 200 MHz clock and a plain register port of 16-bit words.
package cxo_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word indices
  localparam logic [3:0] REG_CMD      = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;
  localparam logic [3:0] REG_ACC      = 4'h2;
  localparam logic [3:0] REG_INDEX_LO = 4'h3;
  localparam logic [3:0] REG_INDEX_HI = 4'h4;
  localparam logic [3:0] REG_SP       = 4'h5;
  localparam logic [3:0] REG_FLAGS    = 4'h6;
  localparam logic [3:0] REG_PC       = 4'h7;
  localparam logic [3:0] REG_PROBE    = 4'h8;
  localparam logic [3:0] REG_PROBE_EA = 4'h9;

  // Opcodes
  localparam logic [7:0] OP_ACC_TO_INDEX   = 8'h97;
  localparam logic [7:0] OP_FLAGS_TO_ACC   = 8'h85;
  localparam logic [7:0] OP_CHK_DIRECT     = 8'h3D;
  localparam logic [7:0] OP_CHK_ACC        = 8'h4D;
  localparam logic [7:0] OP_CHK_INDEX      = 8'h5D;
  localparam logic [7:0] OP_CHK_OFS8       = 8'h6D;
  localparam logic [7:0] OP_CHK_IX         = 8'h7D;
  localparam logic [7:0] OP_STACK_TO_INDEX = 8'h95;
  localparam logic [7:0] OP_INDEX_TO_ACC   = 8'h9F;
  localparam logic [7:0] OP_INDEX_TO_STACK = 8'h94;
  localparam logic [7:0] OP_PREFIX         = 8'h9E;
  localparam logic [7:0] OP_NO_PREFIX      = 8'h00;

  // Cycle counts per instruction
  localparam logic [3:0] CYC_ILLEGAL  = 4'h0;
  localparam logic [3:0] CYC_COPY     = 4'h1;
  localparam logic [3:0] CYC_STACK    = 4'h2;
  localparam logic [3:0] CYC_CHK_REG  = 4'h1;
  localparam logic [3:0] CYC_CHK_DIR  = 4'h3;
  localparam logic [3:0] CYC_CHK_OFS8 = 4'h3;
  localparam logic [3:0] CYC_CHK_IX   = 4'h2;
  localparam logic [3:0] CYC_CHK_STK8 = 4'h4;

  // Flag register bit positions
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_MASK = 8'h9F;

  // Status register fields
  localparam int STS_BUSY    = 0;
  localparam int STS_ILLEGAL = 1;
  localparam int STS_CYC_LSB = 8;

  // Reset values
  localparam logic [7:0]  RST_ACC   = 8'h00;
  localparam logic [7:0]  RST_INDEX = 8'h00;
  localparam logic [15:0] RST_SP    = 16'h00FF;
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  PAGE_ZERO = 8'h00;

  // Operand address forms
  typedef enum logic [2:0] {
    MODE_DIRECT             = 3'b000,
    MODE_INDEX_NO_OFFSET    = 3'b001,
    MODE_INDEX_8BIT_OFFSET  = 3'b010,
    MODE_STACK_OFFSET_8BIT  = 3'b011,
    MODE_INDEX_16BIT_OFFSET = 3'b100,
    MODE_FULL_ADDRESS       = 3'b101,
    MODE_NO_OPERAND         = 3'b110
  } cxo_mode_e;

endpackage

// File: rtl/cxo_opfetch.sv
// Operand address fetcher: pulls offset or address bytes after the opcode.
// Assumes memory read data arrive one cycle after the read strobe.
`timescale 1ns/1ps
module cxo_opfetch (
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // Control
  input  wire logic              i_start,
  input  wire cxo_pkg::cxo_mode_e i_mode,
  // Pointer sources
  input  wire logic [15:0]       i_pc,
  input  wire logic [15:0]       i_hx,
  input  wire logic [15:0]       i_sp,
  // Memory read side
  input  wire logic [7:0]        i_rdata,
  output logic                   o_rd,
  output logic [15:0]            o_addr,
  output logic                   o_pc_inc,
  // Result
  output logic                   o_busy,
  output logic                   o_ea_valid,
  output logic [15:0]            o_ea
);

  typedef enum logic [1:0] {
    F_IDLE  = 2'b00,
    F_BYTE1 = 2'b01,
    F_BYTE2 = 2'b10
  } cxo_fstate_e;

  cxo_fstate_e        state_reg;
  cxo_fstate_e        state_next;
  cxo_pkg::cxo_mode_e mode_reg;
  cxo_pkg::cxo_mode_e mode_next;
  logic [7:0]         hi_reg;
  logic [7:0]         hi_next;

  // Next state, byte requests and address forming
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    hi_next    = hi_reg;
    o_rd       = 1'b0;
    o_addr     = i_pc;
    o_pc_inc   = 1'b0;
    o_ea_valid = 1'b0;
    o_ea       = i_hx;
    case (state_reg)
      F_IDLE: begin
        if (i_start) begin
          mode_next = i_mode;
          if (i_mode == cxo_pkg::MODE_INDEX_NO_OFFSET) begin
            o_ea_valid = 1'b1;
          end else if (i_mode != cxo_pkg::MODE_NO_OPERAND) begin
            o_rd       = 1'b1;
            o_pc_inc   = 1'b1;
            state_next = F_BYTE1;
          end
        end
      end
      F_BYTE1: begin
        if (mode_reg == cxo_pkg::MODE_INDEX_16BIT_OFFSET ||
            mode_reg == cxo_pkg::MODE_FULL_ADDRESS) begin
          hi_next    = i_rdata;
          o_rd       = 1'b1;
          o_pc_inc   = 1'b1;
          state_next = F_BYTE2;
        end else begin
          o_ea_valid = 1'b1;
          state_next = F_IDLE;
          case (mode_reg)
            cxo_pkg::MODE_DIRECT:            o_ea = {cxo_pkg::PAGE_ZERO, i_rdata};
            cxo_pkg::MODE_STACK_OFFSET_8BIT: o_ea = i_sp + {8'h00, i_rdata};
            default:                         o_ea = i_hx + {8'h00, i_rdata};
          endcase
        end
      end
      F_BYTE2: begin
        o_ea_valid = 1'b1;
        state_next = F_IDLE;
        if (mode_reg == cxo_pkg::MODE_FULL_ADDRESS) begin
          o_ea = {hi_reg, i_rdata};
        end else begin
          o_ea = i_hx + {hi_reg, i_rdata};
        end
      end
      default: begin
        state_next = F_IDLE;
      end
    endcase
  end

  assign o_busy = (state_reg != F_IDLE);

  // State registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= F_IDLE;
      mode_reg  <= cxo_pkg::MODE_NO_OPERAND;
      hi_reg    <= 8'h00;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      hi_reg    <= hi_next;
    end
  end

endmodule

// File: rtl/cxo_core.sv
// Execution block for register transfers and the negative/zero check.
// Assumes a single-cycle register port and a memory with one-cycle read data.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
//
// Contract
// - Opcode 97 copies accumulator into index low byte, one cycle, flags kept.
// - Opcode 85 loads accumulator with flag register, one cycle, flags kept.
// - Check sets N and Z from operand, clears V, keeps carry, stores nothing.
// - Memory checks: 3D direct 3, 6D offset 3, 7D indexed 2, 9E6D stack 4.
// - Opcode 95 loads index pair with stack pointer plus one, two cycles.
// - Opcode 9F copies index low byte into accumulator, one cycle, flags kept.
// - Opcode 94 loads stack pointer with index pair minus one, two cycles.
// - Eight-bit indexed offset form fetches exactly one offset byte.
// - Sixteen-bit indexed offset form fetches high byte then low byte.
// - Full address form fetches address high byte then low byte.
// - Index is upper and lower byte; byte transfers touch only lower.
module cxo_core (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  // Memory port
  output logic [15:0]      o_mem_addr,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  input  wire logic [7:0]  i_mem_rdata,
  // Status
  output logic             o_busy
);

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_EXEC  = 2'b01,
    S_PROBE = 2'b10
  } cxo_state_e;

  // Cycle count of an opcode, zero when not decoded
  function automatic logic [3:0] cyc_of(input logic [15:0] cmd);
    logic [3:0] c;
    c = cxo_pkg::CYC_ILLEGAL;
    if (cmd[15:8] == cxo_pkg::OP_PREFIX) begin
      if (cmd[7:0] == cxo_pkg::OP_CHK_OFS8) c = cxo_pkg::CYC_CHK_STK8;
    end else if (cmd[15:8] == cxo_pkg::OP_NO_PREFIX) begin
      case (cmd[7:0])
        cxo_pkg::OP_ACC_TO_INDEX:   c = cxo_pkg::CYC_COPY;
        cxo_pkg::OP_FLAGS_TO_ACC:   c = cxo_pkg::CYC_COPY;
        cxo_pkg::OP_INDEX_TO_ACC:   c = cxo_pkg::CYC_COPY;
        cxo_pkg::OP_STACK_TO_INDEX: c = cxo_pkg::CYC_STACK;
        cxo_pkg::OP_INDEX_TO_STACK: c = cxo_pkg::CYC_STACK;
        cxo_pkg::OP_CHK_ACC:        c = cxo_pkg::CYC_CHK_REG;
        cxo_pkg::OP_CHK_INDEX:      c = cxo_pkg::CYC_CHK_REG;
        cxo_pkg::OP_CHK_DIRECT:     c = cxo_pkg::CYC_CHK_DIR;
        cxo_pkg::OP_CHK_OFS8:       c = cxo_pkg::CYC_CHK_OFS8;
        cxo_pkg::OP_CHK_IX:         c = cxo_pkg::CYC_CHK_IX;
        default:                    c = cxo_pkg::CYC_ILLEGAL;
      endcase
    end
    return c;
  endfunction

  // Operand form of an opcode
  function automatic cxo_pkg::cxo_mode_e mode_of(input logic [15:0] cmd);
    cxo_pkg::cxo_mode_e m;
    m = cxo_pkg::MODE_NO_OPERAND;
    if (cmd[15:8] == cxo_pkg::OP_PREFIX) begin
      m = cxo_pkg::MODE_STACK_OFFSET_8BIT;
    end else begin
      case (cmd[7:0])
        cxo_pkg::OP_CHK_DIRECT: m = cxo_pkg::MODE_DIRECT;
        cxo_pkg::OP_CHK_OFS8:   m = cxo_pkg::MODE_INDEX_8BIT_OFFSET;
        cxo_pkg::OP_CHK_IX:     m = cxo_pkg::MODE_INDEX_NO_OFFSET;
        default:                m = cxo_pkg::MODE_NO_OPERAND;
      endcase
    end
    return m;
  endfunction

  cxo_state_e  state_reg;
  cxo_state_e  state_next;
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic [7:0]  index_lo_reg;
  logic [7:0]  index_lo_next;
  logic [7:0]  index_hi_reg;
  logic [7:0]  index_hi_next;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [7:0]  opnd_reg;
  logic [7:0]  opnd_next;
  logic        have_reg;
  logic        have_next;
  logic        pend_reg;
  logic        pend_next;
  logic        illegal_reg;
  logic        illegal_next;
  logic [3:0]  last_cyc_reg;
  logic [3:0]  last_cyc_next;
  logic [15:0] probe_ea_reg;
  logic [15:0] probe_ea_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // Control and datapath values of the current cycle
  logic               idle;
  logic               cmd_go;
  logic               probe_go;
  logic [15:0]        cur_cmd;
  logic [3:0]         cur_cnt;
  logic [3:0]         cur_total;
  cxo_pkg::cxo_mode_e cur_mode;
  logic               mem_form;
  logic               opnd_ok;
  logic [7:0]         opnd_val;
  logic               last;
  logic               sw_wr;
  logic               op_rd;
  logic [15:0]        hx;
  logic               f_start;
  cxo_pkg::cxo_mode_e f_mode;
  logic               f_rd;
  logic [15:0]        f_addr;
  logic               f_pc_inc;
  logic               f_busy;
  logic               f_ea_valid;
  logic [15:0]        f_ea;

  assign idle      = (state_reg == S_IDLE);
  assign hx        = {index_hi_reg, index_lo_reg};
  assign cmd_go    = idle && i_wr && (i_addr == cxo_pkg::REG_CMD) &&
                     (cyc_of(i_wdata) != cxo_pkg::CYC_ILLEGAL);
  assign probe_go  = idle && i_wr && (i_addr == cxo_pkg::REG_PROBE) &&
                     (i_wdata[2:0] <= cxo_pkg::MODE_FULL_ADDRESS);
  assign cur_cmd   = idle ? i_wdata : cmd_reg;
  assign cur_cnt   = idle ? 4'h0 : cnt_reg;
  assign cur_total = cyc_of(cur_cmd);
  assign cur_mode  = mode_of(cur_cmd);
  assign mem_form  = (cur_mode != cxo_pkg::MODE_NO_OPERAND);
  assign opnd_ok   = have_reg || pend_reg;
  assign opnd_val  = pend_reg ? i_mem_rdata : opnd_reg;
  assign last      = (cmd_go || state_reg == S_EXEC) &&
                     (cur_cnt >= cur_total - 4'h1) && (!mem_form || opnd_ok);
  assign sw_wr     = idle && i_wr && !cmd_go && !probe_go;
  assign f_start   = (cmd_go && mem_form) || probe_go;
  assign f_mode    = probe_go ? cxo_pkg::cxo_mode_e'(i_wdata[2:0]) : cur_mode;
  assign op_rd     = f_ea_valid && (state_reg != S_PROBE) && !probe_go;

  // Memory port: fetch bytes, then the single operand read
  assign o_mem_rd   = f_rd || op_rd;
  assign o_mem_addr = f_rd ? f_addr : f_ea;
  assign o_mem_wr   = 1'b0;
  assign o_busy     = !idle;
  assign o_rdata    = rdata_reg;

  cxo_opfetch u_fetch (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_start    (f_start),
    .i_mode     (f_mode),
    .i_pc       (pc_reg),
    .i_hx       (hx),
    .i_sp       (sp_reg),
    .i_rdata    (i_mem_rdata),
    .o_rd       (f_rd),
    .o_addr     (f_addr),
    .o_pc_inc   (f_pc_inc),
    .o_busy     (f_busy),
    .o_ea_valid (f_ea_valid),
    .o_ea       (f_ea)
  );

  // Sequencing, execution and software writes
  always_comb begin
    state_next    = state_reg;
    cmd_next      = cmd_reg;
    cnt_next      = cnt_reg;
    acc_next      = acc_reg;
    index_lo_next = index_lo_reg;
    index_hi_next = index_hi_reg;
    sp_next       = sp_reg;
    flags_next    = flags_reg;
    pc_next       = f_pc_inc ? pc_reg + 16'h0001 : pc_reg;
    opnd_next     = pend_reg ? i_mem_rdata : opnd_reg;
    have_next     = have_reg || pend_reg;
    pend_next     = op_rd;
    illegal_next  = illegal_reg;
    last_cyc_next = last_cyc_reg;
    probe_ea_next = probe_ea_reg;
    // Clearing by software; a new illegal command in the same cycle wins
    if (idle && i_wr && i_addr == cxo_pkg::REG_STATUS && i_wdata[cxo_pkg::STS_ILLEGAL]) begin
      illegal_next = 1'b0;
    end
    if (idle && i_wr && i_addr == cxo_pkg::REG_CMD && !cmd_go) begin
      illegal_next = 1'b1;
    end
    if (cmd_go) begin
      cmd_next   = i_wdata;
      cnt_next   = 4'h1;
      have_next  = 1'b0;
      state_next = S_EXEC;
    end else if (state_reg == S_EXEC) begin
      cnt_next = cnt_reg + 4'h1;
    end
    if (probe_go) begin
      state_next = S_PROBE;
    end
    if (f_ea_valid && (probe_go || state_reg == S_PROBE)) begin
      probe_ea_next = f_ea;
      state_next    = S_IDLE;
    end
    if (last) begin
      state_next    = S_IDLE;
      have_next     = 1'b0;
      last_cyc_next = cur_total;
      case (cur_cmd[7:0])
        cxo_pkg::OP_ACC_TO_INDEX:   index_lo_next = acc_reg;
        cxo_pkg::OP_FLAGS_TO_ACC:   acc_next = flags_reg & cxo_pkg::FLAGS_MASK;
        cxo_pkg::OP_INDEX_TO_ACC:   acc_next = index_lo_reg;
        cxo_pkg::OP_STACK_TO_INDEX: {index_hi_next, index_lo_next} = sp_reg + 16'h0001;
        cxo_pkg::OP_INDEX_TO_STACK: sp_next = hx - 16'h0001;
        cxo_pkg::OP_CHK_ACC: begin
          flags_next[cxo_pkg::FLG_V] = 1'b0;
          flags_next[cxo_pkg::FLG_N] = acc_reg[7];
          flags_next[cxo_pkg::FLG_Z] = (acc_reg == 8'h00);
        end
        cxo_pkg::OP_CHK_INDEX: begin
          flags_next[cxo_pkg::FLG_V] = 1'b0;
          flags_next[cxo_pkg::FLG_N] = index_lo_reg[7];
          flags_next[cxo_pkg::FLG_Z] = (index_lo_reg == 8'h00);
        end
        default: begin
          flags_next[cxo_pkg::FLG_V] = 1'b0;
          flags_next[cxo_pkg::FLG_N] = opnd_val[7];
          flags_next[cxo_pkg::FLG_Z] = (opnd_val == 8'h00);
        end
      endcase
    end
    // Software access to the programmer's registers while idle
    if (sw_wr) begin
      case (i_addr)
        cxo_pkg::REG_ACC:      acc_next = i_wdata[7:0];
        cxo_pkg::REG_INDEX_LO: index_lo_next = i_wdata[7:0];
        cxo_pkg::REG_INDEX_HI: index_hi_next = i_wdata[7:0];
        cxo_pkg::REG_SP:       sp_next = i_wdata;
        cxo_pkg::REG_FLAGS:    flags_next = i_wdata[7:0] & cxo_pkg::FLAGS_MASK;
        cxo_pkg::REG_PC:       pc_next = i_wdata;
        default:               pc_next = pc_next;
      endcase
    end
  end

  // Read data for the cycle after the read strobe
  always_comb begin
    rdata_next = cxo_pkg::RST_WORD;
    if (i_rd) begin
      case (i_addr)
        cxo_pkg::REG_CMD:      rdata_next = cmd_reg;
        cxo_pkg::REG_STATUS: begin
          rdata_next[cxo_pkg::STS_BUSY]    = !idle;
          rdata_next[cxo_pkg::STS_ILLEGAL] = illegal_reg;
          rdata_next[cxo_pkg::STS_CYC_LSB +: 4] = last_cyc_reg;
        end
        cxo_pkg::REG_ACC:      rdata_next = {8'h00, acc_reg};
        cxo_pkg::REG_INDEX_LO: rdata_next = {8'h00, index_lo_reg};
        cxo_pkg::REG_INDEX_HI: rdata_next = {8'h00, index_hi_reg};
        cxo_pkg::REG_SP:       rdata_next = sp_reg;
        cxo_pkg::REG_FLAGS:    rdata_next = {8'h00, flags_reg};
        cxo_pkg::REG_PC:       rdata_next = pc_reg;
        cxo_pkg::REG_PROBE:    rdata_next = {15'h0000, f_busy};
        cxo_pkg::REG_PROBE_EA: rdata_next = probe_ea_reg;
        default:               rdata_next = cxo_pkg::RST_WORD;
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg    <= S_IDLE;
      cmd_reg      <= cxo_pkg::RST_WORD;
      cnt_reg      <= 4'h0;
      acc_reg      <= cxo_pkg::RST_ACC;
      index_lo_reg <= cxo_pkg::RST_INDEX;
      index_hi_reg <= cxo_pkg::RST_INDEX;
      sp_reg       <= cxo_pkg::RST_SP;
      flags_reg    <= cxo_pkg::RST_FLAGS;
      pc_reg       <= cxo_pkg::RST_PC;
      opnd_reg     <= 8'h00;
      have_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      illegal_reg  <= 1'b0;
      last_cyc_reg <= 4'h0;
      probe_ea_reg <= cxo_pkg::RST_WORD;
      rdata_reg    <= cxo_pkg::RST_WORD;
    end else begin
      state_reg    <= state_next;
      cmd_reg      <= cmd_next;
      cnt_reg      <= cnt_next;
      acc_reg      <= acc_next;
      index_lo_reg <= index_lo_next;
      index_hi_reg <= index_hi_next;
      sp_reg       <= sp_next;
      flags_reg    <= flags_next;
      pc_reg       <= pc_next;
      opnd_reg     <= opnd_next;
      have_reg     <= have_next;
      pend_reg     <= pend_next;
      illegal_reg  <= illegal_next;
      last_cyc_reg <= last_cyc_next;
      probe_ea_reg <= probe_ea_next;
      rdata_reg    <= rdata_next;
    end
  end

endmodule

// File: tb/cxo_core_asserts.sv
// Port-level checker for the transfer and negative/zero check block.
// Assumes it is bound to cxo_core and sees a single clock domain.
`timescale 1ns/1ps
module cxo_core_asserts (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst,
  // Register port
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  // Memory port and status
  input wire logic [15:0] o_mem_addr,
  input wire logic        o_mem_rd,
  input wire logic        o_mem_wr,
  input wire logic [7:0]  i_mem_rdata,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Accepted command and probe writes
  logic cmd_ok;
  logic prb_ok;
  assign cmd_ok = i_wr && !o_busy && (i_addr == cxo_pkg::REG_CMD);
  assign prb_ok = i_wr && !o_busy && (i_addr == cxo_pkg::REG_PROBE);

  a_acc_index_one: assert property (cmd_ok && i_wdata == 16'h0097 |=> !o_busy)
    else $error("acc to index copy took more than one cycle");
  a_flags_acc_one: assert property (cmd_ok && i_wdata == 16'h0085 |=> !o_busy)
    else $error("flags to acc copy took more than one cycle");
  a_index_acc_one: assert property (cmd_ok && i_wdata == 16'h009F |=> !o_busy)
    else $error("index to acc copy took more than one cycle");
  a_stack_index_two: assert property (cmd_ok && i_wdata == 16'h0095 |=> o_busy ##1 !o_busy)
    else $error("stack to index copy not two cycles");
  a_index_stack_two: assert property (cmd_ok && i_wdata == 16'h0094 |=> o_busy ##1 !o_busy)
    else $error("index to stack copy not two cycles");
  a_check_reg_one: assert property (cmd_ok && i_wdata[7:4] inside {4'h4, 4'h5}
    && i_wdata[3:0] == 4'hD && i_wdata[15:8] == 8'h00 |-> !o_mem_rd ##1 !o_busy)
    else $error("register check read memory or overran");
  a_check_dir_walk: assert property (cmd_ok && i_wdata == 16'h003D |-> o_mem_rd
    ##1 (o_mem_rd && o_busy && o_mem_addr == {8'h00, i_mem_rdata})
    ##1 (o_busy && !o_mem_rd) ##1 !o_busy)
    else $error("direct check walk wrong");
  a_check_ix_walk: assert property (cmd_ok && i_wdata == 16'h007D
    |-> o_mem_rd ##1 (o_busy && !o_mem_rd) ##1 !o_busy)
    else $error("indexed check walk wrong");
  a_check_ofs8_walk: assert property (cmd_ok && i_wdata == 16'h006D
    |-> o_mem_rd ##1 o_mem_rd ##1 (o_busy && !o_mem_rd) ##1 !o_busy)
    else $error("offset check fetched wrong byte count");
  a_check_stk8_walk: assert property (cmd_ok && i_wdata == 16'h9E6D
    |-> o_mem_rd ##1 o_mem_rd ##1 (o_busy && !o_mem_rd)[*2] ##1 !o_busy)
    else $error("stack offset check walk wrong");
  a_probe_full_seq: assert property (prb_ok && i_wdata[2:0] == 3'h5 |-> o_mem_rd
    ##1 (o_mem_rd && o_mem_addr == $past(o_mem_addr) + 16'h0001) ##1 !o_mem_rd)
    else $error("full address bytes not fetched in sequence");
  a_probe_wide_seq: assert property (prb_ok && i_wdata[2:0] == 3'h4 |-> o_mem_rd
    ##1 (o_mem_rd && o_mem_addr == $past(o_mem_addr) + 16'h0001) ##1 !o_mem_rd)
    else $error("wide offset bytes not fetched in sequence");
  a_no_mem_write: assert property (!o_mem_wr)
    else $error("memory write strobe raised");
endmodule

bind cxo_core cxo_core_asserts u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
  .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy)
);

// File: tb/tb_top.sv
// Self-checking bench for the transfer and negative/zero check block.
// Assumes cxo_core alone; the bench is register master and memory.
`timescale 1ns/1ps
module tb_top;
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_mem_rdata = 8'h00;
  logic [15:0] o_rdata;
  logic [15:0] o_mem_addr;
  logic        o_mem_rd;
  logic        o_mem_wr;
  logic        o_busy;
  logic [7:0]  mem [logic [15:0]];
  int          n_mismatch = 0;
  int          checks = 0;
  int          n_rd = 0;

  // Clock
  always #2.5 i_mclk = ~i_mclk;

  cxo_core dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy)
  );

  // Memory answers a cycle after each read; idle bus toggles
  always @(posedge i_mclk) begin
    if (o_mem_rd) begin
      i_mem_rdata <= mem.exists(o_mem_addr) ? mem[o_mem_addr] : 8'hEE;
      n_rd <= n_rd + 1;
    end else
      i_mem_rdata <= ~i_mem_rdata;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write, then wait boundedly until the block is idle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    int k;
    k = 0;
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
    #1;
    while (o_busy !== 1'b0 && k < 50) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk({15'h0000, o_busy}, 16'h0000);
    @(posedge i_mclk);
  endtask

  // Read; data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
    @(posedge i_mclk);
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Register copies, flags kept, carry into index high byte
  task automatic t_xfer;
    wr(cxo_pkg::REG_FLAGS, 16'h0093);
    wr(cxo_pkg::REG_ACC, 16'h003C);
    wr(cxo_pkg::REG_INDEX_HI, 16'h0012);
    wr(cxo_pkg::REG_CMD, 16'h0097);
    rc(cxo_pkg::REG_INDEX_LO, 16'h003C);
    rc(cxo_pkg::REG_INDEX_HI, 16'h0012);
    rc(cxo_pkg::REG_FLAGS, 16'h0093);
    wr(cxo_pkg::REG_ACC, 16'h0000);
    wr(cxo_pkg::REG_CMD, 16'h009F);
    rc(cxo_pkg::REG_ACC, 16'h003C);
    wr(cxo_pkg::REG_CMD, 16'h0085);
    rc(cxo_pkg::REG_ACC, 16'h0093);
    wr(cxo_pkg::REG_CMD, 16'h0094);
    rc(cxo_pkg::REG_SP, 16'h123B);
    wr(cxo_pkg::REG_INDEX_HI, 16'h0000);
    wr(cxo_pkg::REG_SP, 16'h00FF);
    wr(cxo_pkg::REG_CMD, 16'h0095);
    rc(cxo_pkg::REG_INDEX_HI, 16'h0001);
    rc(cxo_pkg::REG_INDEX_LO, 16'h0000);
    rc(cxo_pkg::REG_FLAGS, 16'h0093);
  endtask

  // Every check form against negative, zero and positive operands
  task automatic t_check;
    logic [15:0] ops [6] = '{16'h004D, 16'h005D, 16'h003D, 16'h007D, 16'h006D, 16'h9E6D};
    logic [15:0] eas [6] = '{16'h0000, 16'h0000, 16'h0020, 16'h0130, 16'h0135, 16'h0205};
    logic [3:0]  cyc [6] = '{4'h1, 4'h1, 4'h3, 4'h2, 4'h3, 4'h4};
    logic [3:0]  nr [6] = '{4'h0, 4'h0, 4'h2, 4'h1, 4'h2, 4'h2};
    logic [7:0]  vals [3] = '{8'h80, 8'h00, 8'h41};
    logic [7:0]  v;
    logic [15:0] s;
    int          r0;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        v = vals[j];
        mem.delete();
        mem[16'h0040] = (i == 2) ? 8'h20 : 8'h05;
        mem[eas[i]] = v;
        wr(cxo_pkg::REG_FLAGS, 16'h0083);
        wr(cxo_pkg::REG_ACC, {8'h00, (i == 0) ? v : 8'h77});
        wr(cxo_pkg::REG_INDEX_HI, 16'h0001);
        wr(cxo_pkg::REG_INDEX_LO, {8'h00, (i == 1) ? v : 8'h30});
        wr(cxo_pkg::REG_SP, 16'h0200);
        wr(cxo_pkg::REG_PC, 16'h0040);
        r0 = n_rd;
        wr(cxo_pkg::REG_CMD, ops[i]);
        rc(cxo_pkg::REG_FLAGS, {8'h00, 8'h01 | {5'h00, v[7], v == 8'h00, 1'b0}});
        rc(cxo_pkg::REG_ACC, {8'h00, (i == 0) ? v : 8'h77});
        chk({12'h000, 4'(n_rd - r0)}, {12'h000, nr[i]});
        rd(cxo_pkg::REG_STATUS, s);
        chk({12'h000, s[11:8]}, {12'h000, cyc[i]});
      end
    end
  endtask

  // Operand address fetch for every probe form
  task automatic t_probe;
    logic [2:0]  md [6] = '{3'h2, 3'h4, 3'h5, 3'h0, 3'h1, 3'h3};
    logic [15:0] ex [6] = '{16'h0142, 16'h1364, 16'h1234, 16'h0012, 16'h0130, 16'h0212};
    logic [15:0] pc [6] = '{16'h0041, 16'h0042, 16'h0042, 16'h0041, 16'h0040, 16'h0041};
    mem.delete();
    mem[16'h0040] = 8'h12;
    mem[16'h0041] = 8'h34;
    for (int i = 0; i < 6; i++) begin
      wr(cxo_pkg::REG_SP, 16'h0200);
      wr(cxo_pkg::REG_INDEX_HI, 16'h0001);
      wr(cxo_pkg::REG_INDEX_LO, 16'h0030);
      wr(cxo_pkg::REG_PC, 16'h0040);
      wr(cxo_pkg::REG_PROBE, {13'h0000, md[i]});
      rc(cxo_pkg::REG_PROBE_EA, ex[i]);
      rc(cxo_pkg::REG_PC, pc[i]);
    end
  endtask

  // Write while busy dropped, busy bit, undecoded command, flag clear, unmapped read
  task automatic t_illegal;
    logic [15:0] s;
    i_addr  <= cxo_pkg::REG_CMD;
    i_wdata <= 16'h9E6D;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_addr  <= cxo_pkg::REG_ACC;
    i_wdata <= 16'h00AA;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    rd(cxo_pkg::REG_STATUS, s);
    chk({15'h0000, s[0]}, 16'h0001);
    @(posedge i_mclk);
    rc(cxo_pkg::REG_ACC, 16'h0077);
    wr(cxo_pkg::REG_CMD, 16'h0001);
    rc(cxo_pkg::REG_CMD, 16'h9E6D);
    rd(cxo_pkg::REG_STATUS, s);
    chk({15'h0000, s[1]}, 16'h0001);
    wr(cxo_pkg::REG_STATUS, 16'h0002);
    rd(cxo_pkg::REG_STATUS, s);
    chk({15'h0000, s[1]}, 16'h0000);
    rc(4'hF, 16'h0000);
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    give_verdict;
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_xfer;
    t_check;
    t_probe;
    t_illegal;
    give_verdict;
  end
endmodule
